// File: design/mcu_timing_pkg.sv
// Purpose: Shared constants and types of the instruction timing core.
// Assumes: One system clock, program memory with a same-cycle read path.
// Notes: Cycle figures are counts of system clocks, not machine cycles.
package mcu_timing_pkg;

  // Clock rate and limits
  localparam int unsigned CLK_SYS_MHZ = 125;
  localparam int unsigned MAX_CORE_MHZ = 24;
  localparam int unsigned PEAK_MEGA_INSTR_PER_SEC = MAX_CORE_MHZ;
  localparam int unsigned INSTR_COUNT = 109;
  localparam logic [3:0] MAX_INSTR_CYCLES = 4'h8;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Opcodes with their own timing figures
  localparam logic [7:0] OPC_NOP = 8'h00;
  localparam logic [7:0] OPC_JC = 8'h40;
  localparam logic [7:0] OPC_ORL_DIR_IMM = 8'h43;
  localparam logic [7:0] OPC_INC_DIR = 8'h05;
  localparam logic [7:0] OPC_ADD_IND0 = 8'h26;
  localparam logic [7:0] OPC_ADD_DIR = 8'h25;
  localparam logic [7:0] OPC_DIV = 8'h84;
  localparam logic [7:0] OPC_INC_DATA_PTR = 8'hA3;
  localparam logic [7:0] OPC_UNDEFINED = 8'hA5;

  typedef enum logic [3:0] {
    ALU_NONE = 4'h0,
    ALU_INC = 4'h1,
    ALU_DEC = 4'h2,
    ALU_ADD = 4'h3,
    ALU_ADDC = 4'h4,
    ALU_ORL = 4'h5,
    ALU_ANL = 4'h6,
    ALU_XRL = 4'h7,
    ALU_SUBB = 4'h8
  } alu_op_t;

  typedef enum logic [2:0] {
    OPND_NONE = 3'h0,
    OPND_ACC = 3'h1,
    OPND_REG = 3'h2,
    OPND_DIRECT = 3'h3,
    OPND_INDIRECT = 3'h4,
    OPND_IMM = 3'h5,
    OPND_DATA_PTR = 3'h6
  } opnd_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } core_state_t;

endpackage : mcu_timing_pkg

// File: design/mcu_opcode_decoder.sv
// Purpose: Classify one opcode: length, clocks, branch kind, operation and operands.
// Assumes: Standard 8-bit controller opcode map; A5 is the single undefined code.
// Notes: Purely combinational.
`timescale 1ns/1ps
module mcu_opcode_decoder
  import mcu_timing_pkg::*;
(
  input wire logic [7:0] opcode, // Opcode byte
  output logic [1:0] len, // Instruction length in bytes
  output logic [3:0] cycles, // Clocks when no branch is taken
  output logic cond, // Conditional branch, one more clock if taken
  output logic undefined, // Code outside the instruction set
  output alu_op_t alu, // Arithmetic or logic operation
  output opnd_mode_t src, // Operand source
  output opnd_mode_t dst // Result destination
);

  logic [3:0] hi;
  logic [3:0] lo;

  function automatic alu_op_t alu_of(input logic [3:0] h);
    case (h)
      4'h0: alu_of = ALU_INC;
      4'h1: alu_of = ALU_DEC;
      4'h2: alu_of = ALU_ADD;
      4'h3: alu_of = ALU_ADDC;
      4'h4: alu_of = ALU_ORL;
      4'h5: alu_of = ALU_ANL;
      4'h6: alu_of = ALU_XRL;
      4'h9: alu_of = ALU_SUBB;
      default: alu_of = ALU_NONE;
    endcase
  endfunction : alu_of

  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  always_comb begin
    len = 2'd1;
    cycles = 4'h1;
    cond = 1'b0;
    undefined = 1'b0;
    alu = ALU_NONE;
    src = OPND_NONE;
    dst = OPND_NONE;
    case (lo)
      4'h0: begin
        if (hi == 4'h0) begin
          len = 2'd1;
        end else if (hi <= 4'h3) begin
          len = 2'd3;
          cycles = 4'h3;
          cond = 1'b1;
        end else if (hi <= 4'h7) begin
          len = 2'd2;
          cycles = 4'h2;
          cond = 1'b1;
        end else if (hi == 4'h8) begin
          len = 2'd2;
          cycles = 4'h3;
        end else if (hi == 4'h9) begin
          len = 2'd3;
          cycles = 4'h3;
        end else if (hi <= 4'hD) begin
          len = 2'd2;
          cycles = 4'h2;
        end else begin
          cycles = 4'h3;
        end
      end
      4'h1: begin
        len = 2'd2;
        cycles = 4'h3;
      end
      4'h2: begin
        if (hi <= 4'h1) begin
          len = 2'd3;
          cycles = 4'h4;
        end else if (hi <= 4'h3) begin
          cycles = 4'h5;
        end else if (hi <= 4'hD) begin
          len = 2'd2;
          cycles = 4'h2;
          if (hi <= 4'h6) begin
            alu = alu_of(hi);
            src = OPND_ACC;
            dst = OPND_DIRECT;
          end
        end else begin
          cycles = 4'h3;
        end
      end
      4'h3: begin
        if (hi >= 4'h4 && hi <= 4'h6) begin
          len = 2'd3;
          cycles = 4'h3;
          alu = alu_of(hi);
          src = OPND_IMM;
          dst = OPND_DIRECT;
        end else if (hi == 4'hA) begin
          alu = ALU_INC;
          src = OPND_DATA_PTR;
          dst = OPND_DATA_PTR;
        end else if ((hi >= 4'h7 && hi <= 4'h9) || hi >= 4'hE) begin
          cycles = 4'h3;
        end
      end
      4'h4: begin
        if (hi <= 4'h1) begin
          alu = alu_of(hi);
          src = OPND_ACC;
          dst = OPND_ACC;
        end else if (hi == 4'h8) begin
          cycles = MAX_INSTR_CYCLES;
        end else if (hi == 4'hA) begin
          cycles = 4'h4;
        end else if (hi == 4'hB) begin
          len = 2'd3;
          cycles = 4'h3;
          cond = 1'b1;
        end else if (hi <= 4'h9) begin
          len = 2'd2;
          cycles = 4'h2;
          src = OPND_IMM;
          dst = OPND_ACC;
          alu = alu_of(hi);
        end
      end
      4'h5: begin
        len = 2'd2;
        cycles = 4'h2;
        src = OPND_DIRECT;
        alu = alu_of(hi);
        dst = (hi <= 4'h1) ? OPND_DIRECT : OPND_ACC;
        if (hi == 4'h7 || hi == 4'h8) begin
          len = 2'd3;
          cycles = 4'h3;
        end else if (hi == 4'hB) begin
          len = 2'd3;
          cycles = 4'h4;
          cond = 1'b1;
        end else if (hi == 4'hD) begin
          len = 2'd3;
          cycles = 4'h3;
          cond = 1'b1;
        end else if (hi == 4'hA) begin
          len = 2'd1;
          cycles = 4'h1;
          src = OPND_NONE;
          dst = OPND_NONE;
          undefined = 1'b1;
        end
      end
      4'h6, 4'h7: begin
        cycles = 4'h2;
        src = OPND_INDIRECT;
        alu = alu_of(hi);
        dst = (hi <= 4'h1) ? OPND_INDIRECT : OPND_ACC;
        if (hi == 4'h7 || hi == 4'h8 || hi == 4'hA) begin
          len = 2'd2;
        end else if (hi == 4'hB) begin
          len = 2'd3;
          cycles = 4'h4;
          cond = 1'b1;
        end
      end
      default: begin
        src = OPND_REG;
        alu = alu_of(hi);
        dst = (hi <= 4'h1) ? OPND_REG : OPND_ACC;
        if (hi == 4'h7 || hi == 4'h8 || hi == 4'hA) begin
          len = 2'd2;
          cycles = 4'h2;
        end else if (hi == 4'hB) begin
          len = 2'd3;
          cycles = 4'h3;
          cond = 1'b1;
        end else if (hi == 4'hD) begin
          len = 2'd2;
          cycles = 4'h2;
          cond = 1'b1;
        end
      end
    endcase
    if (alu == ALU_NONE && !(lo == 4'h3 && hi == 4'hA)) begin
      src = (lo >= 4'h5) ? src : OPND_NONE;
      dst = OPND_NONE;
    end
  end

endmodule : mcu_opcode_decoder

// File: design/mcu_core_timing.sv
// Purpose: Fetch and instruction timing sequencer of the 8-bit controller core.
// Assumes: CODE_DATA answers CODE_ADDR in the same cycle; datapath is on CLK_SYS.
// Notes: Opcode map follows the standard 8-bit instruction set.
// What this block does
// - Decode every opcode exactly as the standard 8-bit controller set does
// - Count and sequence all execution in single system clocks, no machine cycles
// - Most instructions take as many clocks as they have program bytes
// - Conditional branch takes one clock less when the branch is not taken
// - No instruction exceeds eight clocks; divide uses all eight
// - Arithmetic or logic with a working register: one byte, one clock
// - Arithmetic or logic with a direct byte: two bytes, two clocks
// - Arithmetic or logic through an indirect pointer: one byte, two clocks
// - Arithmetic or logic with an immediate: two bytes, two clocks
// - Increment, decrement: one clock on accumulator, register or data pointer, two otherwise
// - Data pointer increment: one byte, one clock
// - Logic of accumulator into direct byte: two bytes, two clocks, written back
// - Logic of immediate into direct byte: three bytes, three clocks
// - Run up to 24 MHz, one instruction per clock for one-clock instructions
// - Decoder holds exactly 109 instructions
`timescale 1ns/1ps
module mcu_core_timing
  import mcu_timing_pkg::*;
(
  input wire logic CLK_SYS, // System clock
  input wire logic RST_N, // Asynchronous reset, active low
  output logic [15:0] CODE_ADDR, // Program memory address
  output logic CODE_RD, // Program memory read strobe
  input wire logic [7:0] CODE_DATA, // Program memory read data
  input wire logic BRANCH_TAKEN, // Datapath: branch condition holds
  input wire logic PC_LOAD, // Datapath: load new program counter
  input wire logic [15:0] PC_NEW, // Datapath: new program counter
  output logic INSTR_START, // First clock of an instruction
  output logic INSTR_DONE, // Final clock of an instruction
  output logic [7:0] OPCODE, // Opcode of the running instruction
  output logic [7:0] OPERAND1, // Second instruction byte
  output logic [7:0] OPERAND2, // Third instruction byte
  output logic [3:0] CYCLE_IDX, // Clock index inside the instruction
  output alu_op_t ALU_OP, // Operation of the running instruction
  output opnd_mode_t SRC_MODE, // Operand source
  output opnd_mode_t DST_MODE, // Result destination
  output logic UNDEFINED_OP // Running opcode is outside the set
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;
  core_state_t state_reg;
  logic [15:0] pc_reg;
  logic [3:0] cyc_reg;
  logic ext_reg;
  logic [7:0] opcode_reg;
  logic [7:0] cur_op;
  logic exec;
  logic [1:0] d_len;
  logic [3:0] d_cyc;
  logic d_cond;
  logic d_undef;
  alu_op_t d_alu;
  opnd_mode_t d_src;
  opnd_mode_t d_dst;
  logic last_nt;
  logic done;

  // Reset release through two flip-flops
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  assign exec = (state_reg == ST_EXEC);
  // Opcode is decoded straight off the bus in the first clock
  assign cur_op = (cyc_reg == 4'h0) ? CODE_DATA : opcode_reg;

  mcu_opcode_decoder u_dec (
    .opcode(cur_op),
    .len(d_len),
    .cycles(d_cyc),
    .cond(d_cond),
    .undefined(d_undef),
    .alu(d_alu),
    .src(d_src),
    .dst(d_dst)
  );

  assign last_nt = exec && !ext_reg && (cyc_reg == d_cyc - 4'h1);
  assign done = ext_reg || (last_nt && !(d_cond && BRANCH_TAKEN));

  assign CODE_RD = exec && !ext_reg && (cyc_reg < {2'b00, d_len});
  assign CODE_ADDR = pc_reg;
  assign INSTR_START = exec && (cyc_reg == 4'h0);
  assign INSTR_DONE = done;
  assign OPCODE = cur_op;
  assign CYCLE_IDX = cyc_reg;
  assign ALU_OP = d_alu;
  assign SRC_MODE = d_src;
  assign DST_MODE = d_dst;
  assign UNDEFINED_OP = exec && d_undef;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= ST_EXEC;
        ST_EXEC: state_reg <= ST_EXEC;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // One count per system clock; cleared to zero after the final clock
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg <= 4'h0;
    end else if (done) begin
      cyc_reg <= 4'h0;
    end else if (exec) begin
      cyc_reg <= cyc_reg + 4'h1;
    end
  end

  // Taken branch adds exactly one clock
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ext_reg <= 1'b0;
    end else begin
      ext_reg <= last_nt && d_cond && BRANCH_TAKEN;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= PC_RESET;
    end else if (PC_LOAD) begin
      pc_reg <= PC_NEW;
    end else if (CODE_RD) begin
      pc_reg <= pc_reg + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      opcode_reg <= OPC_NOP;
      OPERAND1 <= BYTE_RESET;
      OPERAND2 <= BYTE_RESET;
    end else if (CODE_RD) begin
      if (cyc_reg == 4'h0) begin
        opcode_reg <= CODE_DATA;
      end else if (cyc_reg == 4'h1) begin
        OPERAND1 <= CODE_DATA;
      end else begin
        OPERAND2 <= CODE_DATA;
      end
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!rst_n);

  sequence s_start(logic [7:0] op);
    INSTR_START && (OPCODE == op);
  endsequence

  sequence s_two_clocks;
    !INSTR_DONE ##1 INSTR_DONE;
  endsequence

  no_idle_gap_a: assert property (INSTR_DONE |=> INSTR_START)
    else $error("next instruction did not start right after the final clock");

  cycle_bound_a: assert property (exec |-> CYCLE_IDX < MAX_INSTR_CYCLES)
    else $error("instruction ran past eight clocks");

  divide_eight_a: assert property (s_start(OPC_DIV) |-> (!INSTR_DONE)[*7] ##1 INSTR_DONE)
    else $error("divide did not take eight clocks");

  reg_arith_a: assert property (INSTR_START && OPCODE[3] && ALU_OP != ALU_NONE |-> INSTR_DONE
      && CODE_RD)
    else $error("register operation not single clock");

  direct_arith_a: assert property (s_start(OPC_ADD_DIR) |-> CODE_RD ##1
      (CODE_RD && INSTR_DONE))
    else $error("direct operand not two bytes in two clocks");

  indirect_arith_a: assert property (s_start(OPC_ADD_IND0) |-> s_two_clocks and
      (CODE_RD ##1 !CODE_RD))
    else $error("indirect operand not one byte in two clocks");

  inc_direct_a: assert property (s_start(OPC_INC_DIR) |-> !INSTR_DONE ##1 INSTR_DONE)
    else $error("direct increment not two clocks");

  data_ptr_inc_a: assert property (s_start(OPC_INC_DATA_PTR) |-> INSTR_DONE && CODE_RD
      && DST_MODE == OPND_DATA_PTR)
    else $error("data pointer increment not single clock");

  dir_imm_logic_a: assert property (s_start(OPC_ORL_DIR_IMM) |-> (CODE_RD && !INSTR_DONE)[*2]
      ##1 (CODE_RD && INSTR_DONE))
    else $error("immediate into direct not three bytes in three clocks");

  branch_nt_a: assert property (s_start(OPC_JC) ##1 !BRANCH_TAKEN |-> INSTR_DONE)
    else $error("untaken branch not ended at its short count");

  branch_tk_a: assert property (s_start(OPC_JC) ##1 BRANCH_TAKEN |-> !INSTR_DONE ##1
      (INSTR_DONE && !CODE_RD))
    else $error("taken branch not one clock longer");

  pc_step_a: assert property (CODE_RD && !PC_LOAD |=> CODE_ADDR == $past(CODE_ADDR) + 16'h0001)
    else $error("program counter did not step after a fetch");

endmodule : mcu_core_timing

// File: sim/code_rom_model.sv
// Purpose: Program memory beside the timing core, read in the same cycle.
// Assumes: Bench writes mem ahead of each fetch; 512 bytes decoded.
// Notes: While not read the data lines show the inverse of the last byte.
`timescale 1ns/1ps
module code_rom_model (
  input wire logic clk, // System clock
  input wire logic [15:0] addr, // Fetch address
  input wire logic rd, // Fetch strobe
  output logic [7:0] data // Fetch data
);
  logic [7:0] mem [0:511];
  logic [7:0] last_reg = 8'h00;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'h00;
  end
  always @(posedge clk) begin
    if (rd) last_reg <= data;
  end
  assign data = rd ? mem[addr[8:0]] : ~last_reg;
endmodule : code_rom_model

// File: sim/test_mcu_core_timing.sv
// Purpose: Self-checking bench for the instruction timing core.
// Assumes: Program bytes are placed just before their fetch.
// Notes: Operand bytes are 3C and 5A.
`timescale 1ns/1ps
module test_mcu_core_timing;
  import mcu_timing_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic branch_taken = 1'b0;
  logic pc_load = 1'b0;
  logic [15:0] pc_new = 16'h0000;
  logic [15:0] code_addr;
  logic code_rd;
  logic [7:0] code_data;
  logic instr_start;
  logic instr_done;
  logic [7:0] opcode;
  logic [7:0] operand1;
  logic [7:0] operand2;
  logic [3:0] cycle_idx;
  alu_op_t alu_op;
  opnd_mode_t src_mode;
  opnd_mode_t dst_mode;
  logic undefined_op;
  int fail_count = 0;
  int n_checks = 0;

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  mcu_core_timing u_mcu_core_timing (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .CODE_ADDR(code_addr), .CODE_RD(code_rd), .CODE_DATA(code_data),
    .BRANCH_TAKEN(branch_taken), .PC_LOAD(pc_load), .PC_NEW(pc_new),
    .INSTR_START(instr_start), .INSTR_DONE(instr_done), .OPCODE(opcode),
    .OPERAND1(operand1), .OPERAND2(operand2), .CYCLE_IDX(cycle_idx),
    .ALU_OP(alu_op), .SRC_MODE(src_mode), .DST_MODE(dst_mode),
    .UNDEFINED_OP(undefined_op));
  code_rom_model u_code_rom_model (.clk(clk_sys), .addr(code_addr), .rd(code_rd),
    .data(code_data));

  task summarize;
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Runs one instruction from its first clock; returns in the next one's first clock
  task run_instr(input logic [7:0] op, input int len, input int cyc, input logic taken,
                 input alu_op_t alu, input opnd_mode_t dst, input opnd_mode_t src = OPND_NONE);
    logic [8:0] a;
    int n;
    int rd;
    logic done;
    a = code_addr[8:0];
    u_code_rom_model.mem[a] = op;
    u_code_rom_model.mem[a + 9'h001] = 8'h3C;
    u_code_rom_model.mem[a + 9'h002] = 8'h5A;
    #1;
    check(instr_start, 1'b1);
    check(opcode, op);
    check(undefined_op, op == OPC_UNDEFINED);
    check(alu_op, alu);
    check(dst_mode, dst);
    if (src != OPND_NONE) check(src_mode, src);
    n = 0;
    rd = 0;
    done = 1'b0;
    while (!done && n < 9) begin
      check(cycle_idx, n);
      if (code_rd === 1'b1) rd++;
      if (instr_done === 1'b1) done = 1'b1;
      n++;
      @(posedge clk_sys);
      branch_taken <= taken;
      #2;
    end
    if (!done) begin
      fail_count++;
      summarize();
    end
    check(n, cyc);
    check(rd, len);
    check(instr_start, 1'b1);
    if (len > 1) check(operand1, 8'h3C);
    if (len > 2) check(operand2, 8'h5A);
  endtask : run_instr

  task scen_reset;
    int k;
    repeat (3) @(posedge clk_sys);
    #1;
    check(code_rd, 1'b0);
    check(instr_start, 1'b0);
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    k = 0;
    #1;
    while (instr_start !== 1'b1 && k < 10) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k == 10) begin
      fail_count++;
      summarize();
    end
    check(code_addr, PC_RESET);
  endtask : scen_reset

  task scen_reg_ops;
    run_instr(8'h28, 1, 1, 1'b0, ALU_ADD, OPND_ACC, OPND_REG);
    run_instr(8'h38, 1, 1, 1'b0, ALU_ADDC, OPND_ACC);
    run_instr(8'h98, 1, 1, 1'b0, ALU_SUBB, OPND_ACC);
    run_instr(8'h58, 1, 1, 1'b0, ALU_ANL, OPND_ACC);
    run_instr(8'h48, 1, 1, 1'b0, ALU_ORL, OPND_ACC);
    run_instr(8'h68, 1, 1, 1'b0, ALU_XRL, OPND_ACC);
  endtask : scen_reg_ops

  task scen_acc_modes;
    run_instr(OPC_ADD_DIR, 2, 2, 1'b0, ALU_ADD, OPND_ACC, OPND_DIRECT);
    run_instr(8'h45, 2, 2, 1'b0, ALU_ORL, OPND_ACC, OPND_DIRECT);
    run_instr(OPC_ADD_IND0, 1, 2, 1'b0, ALU_ADD, OPND_ACC, OPND_INDIRECT);
    run_instr(8'h96, 1, 2, 1'b0, ALU_SUBB, OPND_ACC, OPND_INDIRECT);
    run_instr(8'h24, 2, 2, 1'b0, ALU_ADD, OPND_ACC, OPND_IMM);
    run_instr(8'h64, 2, 2, 1'b0, ALU_XRL, OPND_ACC, OPND_IMM);
  endtask : scen_acc_modes

  task scen_inc_dec;
    run_instr(8'h04, 1, 1, 1'b0, ALU_INC, OPND_ACC);
    run_instr(8'h08, 1, 1, 1'b0, ALU_INC, OPND_REG);
    run_instr(OPC_INC_DIR, 2, 2, 1'b0, ALU_INC, OPND_DIRECT);
    run_instr(8'h06, 1, 2, 1'b0, ALU_INC, OPND_INDIRECT);
    run_instr(8'h14, 1, 1, 1'b0, ALU_DEC, OPND_ACC);
    run_instr(8'h16, 1, 2, 1'b0, ALU_DEC, OPND_INDIRECT);
    run_instr(OPC_INC_DATA_PTR, 1, 1, 1'b0, ALU_INC, OPND_DATA_PTR);
  endtask : scen_inc_dec

  task scen_logic_direct;
    run_instr(8'h52, 2, 2, 1'b0, ALU_ANL, OPND_DIRECT, OPND_ACC);
    run_instr(8'h42, 2, 2, 1'b0, ALU_ORL, OPND_DIRECT);
    run_instr(8'h62, 2, 2, 1'b0, ALU_XRL, OPND_DIRECT);
    run_instr(8'h53, 3, 3, 1'b0, ALU_ANL, OPND_DIRECT);
    run_instr(OPC_ORL_DIR_IMM, 3, 3, 1'b0, ALU_ORL, OPND_DIRECT, OPND_IMM);
    run_instr(8'h63, 3, 3, 1'b0, ALU_XRL, OPND_DIRECT);
  endtask : scen_logic_direct

  task scen_branch_div;
    run_instr(OPC_JC, 2, 2, 1'b0, ALU_NONE, OPND_NONE);
    run_instr(OPC_JC, 2, 3, 1'b1, ALU_NONE, OPND_NONE);
    run_instr(OPC_DIV, 1, 8, 1'b0, ALU_NONE, OPND_NONE);
    run_instr(OPC_UNDEFINED, 1, 1, 1'b0, ALU_NONE, OPND_NONE);
    run_instr(OPC_NOP, 1, 1, 1'b0, ALU_NONE, OPND_NONE);
  endtask : scen_branch_div

  // A load during a one-clock instruction wins over the increment
  task scen_pc_load;
    @(posedge clk_sys);
    pc_load <= 1'b1;
    pc_new <= 16'h0100;
    @(posedge clk_sys);
    pc_load <= 1'b0;
    #1;
    check(code_addr, 16'h0100);
    run_instr(OPC_ADD_DIR, 2, 2, 1'b0, ALU_ADD, OPND_ACC);
  endtask : scen_pc_load

  initial begin
    scen_reset();
    scen_reg_ops();
    scen_acc_modes();
    scen_inc_dec();
    scen_logic_direct();
    scen_branch_div();
    scen_pc_load();
    summarize();
  end
endmodule : test_mcu_core_timing
